//--- design/btbce_core.sv
// executor for bit-test branches, decrement loops and cpu control instructions
`timescale 1ns/1ns
// Operation
// - bit-set branch on a short direct bit is 3 bytes and jumps to pc+3+offset when the bit is one.
// - bit-set branch on a peripheral bit is 4 bytes, 11 clocks, jumping to pc+4+offset when set.
// - bit-clear branch on a short direct bit is 4 bytes, jumps to pc+4+offset when zero, 10 or 11 clocks.
// - bit-clear branch on an accumulator bit is 3 bytes, 8 clocks, to pc+3+offset when zero.
// - test-and-clear on a short direct bit jumps to pc+4+offset when set, clears it, 10 or 12 clocks.
// - test-and-clear on a status word bit takes 12 clocks and may change zero, aux carry and carry.
// - test-and-clear through the pointer pair is 3 bytes, 10 clocks, or 12 plus read and write waits outside.
// - decrement loop on b or c decrements first and jumps to pc+2+offset if nonzero, 2 bytes, 6 clocks.
// - decrement loop on a short direct byte writes back and jumps to pc+3+offset if nonzero, 8 or 10.
// - one instruction clock is one cycle of the enabled cpu clock.
// - the short count applies to high-speed ram or no data access, the long count elsewhere.
// - external expansion accesses add the read wait count per read and write wait per write.
// - the word move with the accumulator pair decodes only for the three other pairs.
// - bit-set branch through the pointer pair is 3 bytes, 10 clocks, or 11 plus read waits outside.
module btbce_core
  import btbce_pkg::*;
#(
  parameter int WAIT_W = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic              start,
  input  wire btbce_op_t         op,
  input  wire logic [2:0]        bit_sel,
  input  wire logic [7:0]        signed_jump_offset,
  input  wire logic [7:0]        mem_data,
  input  wire logic [7:0]        acc_in,
  input  wire logic [7:0]        reg_b_in,
  input  wire logic [7:0]        reg_c_in,
  input  wire logic [1:0]        rp_sel,
  input  wire logic [1:0]        bank_operand,
  input  wire logic              hs_ram,
  input  wire logic              ext_area,
  input  wire logic [WAIT_W-1:0] read_waits,
  input  wire logic [WAIT_W-1:0] write_waits,
  input  wire logic [15:0]       pc_in,
  output logic                   busy,
  output logic                   done,
  output logic                   illegal,
  output logic [15:0]            pc_out,
  output logic                   mem_we,
  output logic [7:0]             mem_wdata,
  output logic [7:0]             acc_out,
  output logic [7:0]             reg_b_out,
  output logic [7:0]             reg_c_out,
  output logic [7:0]             program_status_word,
  output logic [1:0]             register_bank_field,
  output logic                   global_interrupt_allow_flag,
  output logic                   halt_req,
  output logic                   stop_req
);

  // =====================
  // decode helpers
  function automatic logic is_bitop(input btbce_op_t o);
    is_bitop = (o >= BTBCE_BT_SADDR) && (o <= BTBCE_BC_HL);
  endfunction

  function automatic logic [7:0] clear_bit(input logic [7:0] v, input logic [2:0] b);
    clear_bit = v & ~(8'h01 << b);
  endfunction

  // =====================
  // combinational execution
  logic [2:0]  len;
  logic [7:0]  cnt_d;
  logic        taken;
  logic        tbit;
  logic [7:0]  src;
  logic [7:0]  dec;
  logic        ill;
  logic [7:0]  rw;
  logic [7:0]  program_status_word_q;
  logic [7:0]  ww;

  assign rw = 8'(read_waits);
  assign ww = 8'(write_waits);

  always_comb begin
    src = mem_data;
    if (op == BTBCE_BT_A || op == BTBCE_BF_A || op == BTBCE_BC_A) begin
      src = acc_in;
    end else if (op == BTBCE_BT_PSW || op == BTBCE_BF_PSW || op == BTBCE_BC_PSW) begin
      src = program_status_word_q;
    end else if (op == BTBCE_DB_B) begin
      src = reg_b_in;
    end else if (op == BTBCE_DB_C) begin
      src = reg_c_in;
    end
  end

  assign tbit = src[bit_sel];
  assign dec  = src - 8'h01;

  always_comb begin
    len   = BTBCE_LEN_2;
    cnt_d = BTBCE_CLK_2;
    taken = 1'b0;
    ill   = 1'b0;
    case (op)
      BTBCE_BT_SADDR: begin
        len = BTBCE_LEN_3;
        cnt_d = hs_ram ? BTBCE_CLK_8 : BTBCE_CLK_9;
        taken = tbit;
      end
      BTBCE_BT_SFR: begin
        len = BTBCE_LEN_4; cnt_d = BTBCE_CLK_11; taken = tbit;
      end
      BTBCE_BT_A: begin
        len = BTBCE_LEN_3; cnt_d = BTBCE_CLK_8; taken = tbit;
      end
      BTBCE_BT_PSW: begin
        len = BTBCE_LEN_3; cnt_d = BTBCE_CLK_9; taken = tbit;
      end
      BTBCE_BT_HL: begin
        len = BTBCE_LEN_3;
        cnt_d = hs_ram ? BTBCE_CLK_10 : BTBCE_CLK_11 + (ext_area ? rw : 8'h00);
        taken = tbit;
      end
      BTBCE_BF_SADDR: begin
        len = BTBCE_LEN_4; cnt_d = hs_ram ? BTBCE_CLK_10 : BTBCE_CLK_11; taken = ~tbit;
      end
      BTBCE_BF_SFR: begin
        len = BTBCE_LEN_4; cnt_d = BTBCE_CLK_11; taken = ~tbit;
      end
      BTBCE_BF_A: begin
        len = BTBCE_LEN_3; cnt_d = BTBCE_CLK_8; taken = ~tbit;
      end
      BTBCE_BF_PSW: begin
        len = BTBCE_LEN_4; cnt_d = BTBCE_CLK_11; taken = ~tbit;
      end
      BTBCE_BF_HL: begin
        len = BTBCE_LEN_3;
        cnt_d = hs_ram ? BTBCE_CLK_10 : BTBCE_CLK_11 + (ext_area ? rw : 8'h00);
        taken = ~tbit;
      end
      BTBCE_BC_SADDR: begin
        len = BTBCE_LEN_4; cnt_d = hs_ram ? BTBCE_CLK_10 : BTBCE_CLK_12; taken = tbit;
      end
      BTBCE_BC_SFR: begin
        len = BTBCE_LEN_4; cnt_d = BTBCE_CLK_12; taken = tbit;
      end
      BTBCE_BC_A: begin
        len = BTBCE_LEN_3; cnt_d = BTBCE_CLK_8; taken = tbit;
      end
      BTBCE_BC_PSW: begin
        len = BTBCE_LEN_4; cnt_d = BTBCE_CLK_12; taken = tbit;
      end
      BTBCE_BC_HL: begin
        len = BTBCE_LEN_3;
        cnt_d = hs_ram ? BTBCE_CLK_10
              : BTBCE_CLK_12 + (ext_area ? rw + ww : 8'h00);
        taken = tbit;
      end
      BTBCE_DB_B, BTBCE_DB_C: begin
        len = BTBCE_LEN_2; cnt_d = BTBCE_CLK_6; taken = (dec != 8'h00);
      end
      BTBCE_DB_SADDR: begin
        len = BTBCE_LEN_3; cnt_d = hs_ram ? BTBCE_CLK_8 : BTBCE_CLK_10;
        taken = (dec != 8'h00);
      end
      BTBCE_SEL: begin
        len = BTBCE_LEN_2; cnt_d = BTBCE_CLK_4;
      end
      BTBCE_EI, BTBCE_DI: begin
        len = BTBCE_LEN_2; cnt_d = BTBCE_CLK_6;
      end
      BTBCE_WORD_MOVE_INSTR_RP: begin
        len = BTBCE_LEN_1; cnt_d = BTBCE_CLK_4;
        ill = (rp_sel == BTBCE_RP_AX);
      end
      BTBCE_HALT, BTBCE_STOP: begin
        len = BTBCE_LEN_2; cnt_d = BTBCE_CLK_6;
      end
      default: begin
        len = BTBCE_LEN_1; cnt_d = BTBCE_CLK_2;
      end
    endcase
  end

  // =====================
  // cycle counter, one count per enabled clock
  logic [7:0] cnt_q;
  logic       busy_q;
  logic       done_q;
  logic       ill_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ill_q  <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        cnt_q  <= cnt_d - 8'h01;
        busy_q <= 1'b1;
        ill_q  <= ill;
      end else if (busy_q) begin
        if (cnt_q == 8'h01 || cnt_q == 8'h00) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // =====================
  // architectural results, captured at start, shown while busy
  logic [15:0] pc_q;
  logic        we_q;
  logic [7:0]  wdata_q;
  logic [7:0]  acc_q;
  logic [7:0]  b_q;
  logic [7:0]  c_q;
  logic [1:0]  bank_q;
  logic        ie_q;
  logic        halt_q;
  logic        stop_q;
  logic [15:0] target;

  assign target = pc_in + 16'(len) + {{8{signed_jump_offset[7]}}, signed_jump_offset};

  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q    <= BTBCE_PC_RST;
      we_q    <= 1'b0;
      wdata_q <= 8'h00;
      acc_q   <= 8'h00;
      b_q     <= 8'h00;
      c_q     <= 8'h00;
    end else if (clk_en && start && !busy_q) begin
      pc_q    <= (taken && !ill) ? target : pc_in + 16'(len);
      acc_q   <= (op == BTBCE_BC_A && tbit) ? clear_bit(acc_in, bit_sel) : acc_in;
      b_q     <= (op == BTBCE_DB_B) ? dec : reg_b_in;
      c_q     <= (op == BTBCE_DB_C) ? dec : reg_c_in;
      we_q    <= ((op == BTBCE_BC_SADDR || op == BTBCE_BC_SFR || op == BTBCE_BC_HL) && tbit)
                 || (op == BTBCE_DB_SADDR);
      wdata_q <= (op == BTBCE_DB_SADDR) ? dec : clear_bit(mem_data, bit_sel);
    end else if (clk_en) begin
      we_q <= 1'b0; // write strobe lasts one enabled cycle
    end
  end

  // status word, bank field and interrupt flag
  always_ff @(posedge clk) begin
    if (rst) begin
      program_status_word_q <= BTBCE_PSW_RST;
      bank_q <= 2'h0;
      ie_q   <= 1'b0;
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (clk_en && start && !busy_q) begin
      if (op == BTBCE_BC_PSW && tbit) begin
        program_status_word_q <= clear_bit(program_status_word_q, bit_sel);
      end
      if (op == BTBCE_SEL) begin
        bank_q <= bank_operand;
      end
      if (op == BTBCE_EI) begin
        ie_q <= 1'b1;
      end else if (op == BTBCE_DI) begin
        ie_q <= 1'b0;
      end
      halt_q <= (op == BTBCE_HALT);
      stop_q <= (op == BTBCE_STOP);
    end
  end

  assign busy      = busy_q;
  assign done      = done_q;
  assign illegal   = ill_q;
  assign pc_out    = pc_q;
  assign mem_we    = we_q;
  assign mem_wdata = wdata_q;
  assign acc_out   = acc_q;
  assign reg_b_out = b_q;
  assign reg_c_out = c_q;
  assign program_status_word         = program_status_word_q;
  assign register_bank_field         = bank_q;
  assign global_interrupt_allow_flag = ie_q;
  assign halt_req  = halt_q;
  assign stop_req  = stop_q;

endmodule // btbce_core

//--- shared/btbce_pkg.sv
// constants for the bit-test branch and control executor
package btbce_pkg;
  // =====================
  // instruction kinds
  typedef enum logic [4:0] {
    BTBCE_NOP, BTBCE_BT_SADDR, BTBCE_BT_SFR, BTBCE_BT_A, BTBCE_BT_PSW, BTBCE_BT_HL,
    BTBCE_BF_SADDR, BTBCE_BF_SFR, BTBCE_BF_A, BTBCE_BF_PSW, BTBCE_BF_HL,
    BTBCE_BC_SADDR, BTBCE_BC_SFR, BTBCE_BC_A, BTBCE_BC_PSW, BTBCE_BC_HL,
    BTBCE_DB_B, BTBCE_DB_C, BTBCE_DB_SADDR, BTBCE_SEL, BTBCE_EI, BTBCE_DI,
    BTBCE_WORD_MOVE_INSTR_RP, BTBCE_HALT, BTBCE_STOP
  } btbce_op_t;
  // =====================
  // byte lengths
  localparam logic [2:0] BTBCE_LEN_1 = 3'h1;
  localparam logic [2:0] BTBCE_LEN_2 = 3'h2;
  localparam logic [2:0] BTBCE_LEN_3 = 3'h3;
  localparam logic [2:0] BTBCE_LEN_4 = 3'h4;
  // =====================
  // base clock counts
  localparam logic [7:0] BTBCE_CLK_2  = 8'h02;
  localparam logic [7:0] BTBCE_CLK_4  = 8'h04;
  localparam logic [7:0] BTBCE_CLK_6  = 8'h06;
  localparam logic [7:0] BTBCE_CLK_8  = 8'h08;
  localparam logic [7:0] BTBCE_CLK_9  = 8'h09;
  localparam logic [7:0] BTBCE_CLK_10 = 8'h0a;
  localparam logic [7:0] BTBCE_CLK_11 = 8'h0b;
  localparam logic [7:0] BTBCE_CLK_12 = 8'h0c;
  // =====================
  // program status word bit positions
  localparam int BTBCE_PSW_CY = 0;
  localparam int BTBCE_PSW_AC = 4;
  localparam int BTBCE_PSW_Z  = 6;
  // =====================
  // reset values
  localparam logic [7:0] BTBCE_PSW_RST = 8'h02;
  localparam logic [15:0] BTBCE_PC_RST = 16'h0000;
  // =====================
  // register pair codes, ax is pair 0
  localparam logic [1:0] BTBCE_RP_AX = 2'h0;
endpackage : btbce_pkg

//--- tb/btbce_core_asserts.sv
// assertions on the ports of the bit-test branch executor
`timescale 1ns/1ns
module btbce_core_asserts
  import btbce_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        start,
  input wire logic        busy,
  input wire logic        done,
  input wire btbce_op_t   op,
  input wire logic        hs_ram,
  input wire logic [2:0]  bit_sel,
  input wire logic [7:0]  mem_data,
  input wire logic [7:0]  signed_jump_offset,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  reg_b_in,
  input wire logic [7:0]  reg_b_out,
  input wire logic [1:0]  bank_operand,
  input wire logic [1:0]  register_bank_field,
  input wire logic [1:0]  rp_sel,
  input wire logic        illegal,
  input wire logic        global_interrupt_allow_flag
);
  // =====================
  // helpers
  logic        acc;
  logic [15:0] ofs_x;
  assign acc = clk_en && start && !busy;
  assign ofs_x = {{8{signed_jump_offset[7]}}, signed_jump_offset};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // =====================
  // checks; counts assume clk_en stays high through an instruction
  a_bt_short_count: assert property (acc && op == BTBCE_BT_SADDR && hs_ram |-> ##8 done)
    else $error("short bit branch count wrong");
  a_bt_saddr_target: assert property (acc && op == BTBCE_BT_SADDR && mem_data[bit_sel] |->
    ##1 pc_out == $past(pc_in) + 16'h0003 + $past(ofs_x)) else $error("bit branch target wrong");
  a_bt_sfr_count: assert property (acc && op == BTBCE_BT_SFR |-> ##11 done)
    else $error("peripheral bit branch count wrong");
  a_bf_acc_count: assert property (acc && op == BTBCE_BF_A |-> ##1 !done [*7] ##1 done)
    else $error("accumulator bit branch count wrong");
  a_db_reg_value: assert property (acc && op == BTBCE_DB_B |=> reg_b_out == $past(reg_b_in) - 8'h01)
    else $error("loop register not decremented");
  a_db_reg_count: assert property (acc && op inside {BTBCE_DB_B, BTBCE_DB_C} |-> ##6 done)
    else $error("loop count wrong");
  a_sel_bank_load: assert property (acc && op == BTBCE_SEL |=> register_bank_field == $past(bank_operand))
    else $error("bank field not loaded");
  a_word_move_pair: assert property (acc && op == BTBCE_WORD_MOVE_INSTR_RP |=> illegal == ($past(rp_sel) == BTBCE_RP_AX))
    else $error("word move legality wrong");
  a_ei_flag_set: assert property (acc && op == BTBCE_EI |-> ##6 done && global_interrupt_allow_flag)
    else $error("interrupt allow wrong");
  a_busy_ends_done: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  a_freeze_holds: assert property (!clk_en |=> $stable(busy) && $stable(pc_out))
    else $error("state moved while frozen");
  c_clear_hl: cover property (acc && op == BTBCE_BC_HL);
  c_loop_mem: cover property (acc && op == BTBCE_DB_SADDR);
  c_frozen: cover property (!clk_en && start);
endmodule // btbce_core_asserts
bind btbce_core btbce_core_asserts i_btbce_core_asserts (.clk, .rst, .clk_en, .start, .busy,
  .done, .op, .hs_ram, .bit_sel, .mem_data, .signed_jump_offset, .pc_in, .pc_out, .reg_b_in,
  .reg_b_out, .bank_operand, .register_bank_field, .rp_sel, .illegal,
  .global_interrupt_allow_flag);

//--- tb/btbce_mem_model.sv
// behavioural operand byte of data memory facing the executor
`timescale 1ns/1ns
module btbce_mem_model (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  input  wire logic       ld,
  input  wire logic [7:0] ld_val,
  output logic [7:0]      rdata
);
  // =====================
  // one byte only; waits are counted by the core, not stretched here
  always_ff @(posedge clk) begin
    if (ld) begin
      rdata <= ld_val;
    end else if (we) begin
      rdata <= wdata;
    end
  end
endmodule // btbce_mem_model

//--- tb/tb_top.sv
// self-checking bench for the bit-test branch and control executor
`timescale 1ns/1ns
`define CK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("MISMATCH %0t %h %h", $time, g, e); end end
module tb_top;
  import btbce_pkg::*;
  logic        clk, rst, clk_en, start, hs_ram, ext_area, ld, busy, done, illegal, mem_we;
  logic        global_interrupt_allow_flag;
  btbce_op_t   op;
  logic [2:0]  bit_sel;
  logic [7:0]  signed_jump_offset, mem_data, acc_in, reg_b_in, reg_c_in, ld_val, mem_wdata;
  logic [7:0]  acc_out, reg_b_out, reg_c_out, program_status_word;
  logic [1:0]  rp_sel, bank_operand, register_bank_field;
  logic [3:0]  read_waits, write_waits;
  logic [15:0] pc_in, pc_out;
  int          failures = 0, checked = 0, cyc = 0, tick = 0;
  btbce_core i_btbce_core (.clk, .rst, .clk_en, .start, .op, .bit_sel, .signed_jump_offset,
    .mem_data, .acc_in, .reg_b_in, .reg_c_in, .rp_sel, .bank_operand, .hs_ram, .ext_area,
    .read_waits, .write_waits, .pc_in, .busy, .done, .illegal, .pc_out, .mem_we, .mem_wdata,
    .acc_out, .reg_b_out, .reg_c_out, .program_status_word, .register_bank_field,
    .global_interrupt_allow_flag, .halt_req(), .stop_req());
  btbce_mem_model i_btbce_mem_model (.clk, .we(mem_we), .wdata(mem_wdata), .ld, .ld_val,
    .rdata(mem_data));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====================
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    tick++;
    if (tick == 20000) begin
      failures++;
      results();
    end
  end
  task automatic results;
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // =====================
  // one instruction: preload operand byte, issue, count cycles to done
  task automatic go(btbce_op_t o, logic [2:0] b, logic [7:0] d, logic [7:0] j, logic h, logic x);
    @(posedge clk);
    ld <= 1'b1;
    ld_val <= d;
    @(posedge clk);
    ld <= 1'b0;
    op <= o;
    bit_sel <= b;
    signed_jump_offset <= j;
    hs_ram <= h;
    ext_area <= x;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    cyc = 1;
    do begin
      @(posedge clk);
      #1 cyc++;
    end while (done !== 1'b1 && cyc < 40);
  endtask
  task automatic t_bit;
    @(posedge clk);
    acc_in <= 8'h80;
    read_waits <= 4'h5;
    go(BTBCE_BT_SADDR, 3'h5, 8'h20, 8'hf0, 1'b1, 1'b0);
    `CK({cyc, pc_out}, {32'd8, 16'h0ff3})
    go(BTBCE_BT_SADDR, 3'h5, 8'h20, 8'hf0, 1'b0, 1'b0);
    `CK(cyc, 9)
    go(BTBCE_BT_SFR, 3'h2, 8'hfb, 8'h10, 1'b0, 1'b0);
    `CK({cyc, pc_out}, {32'd11, 16'h1004})
    go(BTBCE_BF_SADDR, 3'h0, 8'hfe, 8'h7f, 1'b0, 1'b0);
    `CK({cyc, pc_out}, {32'd11, 16'h1083})
    go(BTBCE_BF_A, 3'h7, 8'h00, 8'h7f, 1'b1, 1'b0);
    `CK({cyc, pc_out}, {32'd8, 16'h1003})
    go(BTBCE_BT_HL, 3'h1, 8'h02, 8'h01, 1'b1, 1'b0);
    `CK({cyc, pc_out}, {32'd10, 16'h1004})
    go(BTBCE_BT_HL, 3'h1, 8'h02, 8'h01, 1'b0, 1'b1);
    `CK({cyc, pc_out}, {32'd16, 16'h1004})
  endtask
  task automatic t_clear;
    @(posedge clk);
    read_waits <= 4'h3;
    write_waits <= 4'h2;
    go(BTBCE_BC_SADDR, 3'h3, 8'h0f, 8'h02, 1'b1, 1'b0);
    `CK({cyc, pc_out, mem_data}, {32'd10, 16'h1006, 8'h07})
    go(BTBCE_BC_SADDR, 3'h4, 8'h0f, 8'h02, 1'b0, 1'b0);
    `CK({cyc, pc_out, mem_data}, {32'd12, 16'h1004, 8'h0f})
    go(BTBCE_BC_PSW, 3'h1, 8'h00, 8'h02, 1'b0, 1'b0);
    `CK({cyc, pc_out, program_status_word}, {32'd12, 16'h1006, 8'h00})
    go(BTBCE_BC_HL, 3'h0, 8'h01, 8'h00, 1'b0, 1'b1);
    `CK({cyc, pc_out, mem_data}, {32'd17, 16'h1003, 8'h00})
  endtask
  task automatic t_loop;
    @(posedge clk);
    reg_b_in <= 8'h01;
    reg_c_in <= 8'h05;
    go(BTBCE_DB_B, 3'h0, 8'h00, 8'h10, 1'b1, 1'b0);
    `CK({cyc, pc_out, reg_b_out}, {32'd6, 16'h1002, 8'h00})
    go(BTBCE_DB_C, 3'h0, 8'h00, 8'h10, 1'b1, 1'b0);
    `CK({cyc, pc_out, reg_c_out}, {32'd6, 16'h1012, 8'h04})
    go(BTBCE_DB_SADDR, 3'h0, 8'h02, 8'h10, 1'b1, 1'b0);
    `CK({cyc, pc_out, mem_data}, {32'd8, 16'h1013, 8'h01})
    go(BTBCE_DB_SADDR, 3'h0, 8'h01, 8'h10, 1'b0, 1'b0);
    `CK({cyc, pc_out, mem_data}, {32'd10, 16'h1003, 8'h00})
  endtask
  task automatic t_ctrl;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      bank_operand <= 2'(i);
      rp_sel <= 2'(i);
      go(BTBCE_SEL, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
      `CK(register_bank_field, 2'(i))
      go(BTBCE_WORD_MOVE_INSTR_RP, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
      `CK(illegal, i == 0)
    end
    go(BTBCE_EI, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    `CK({cyc, global_interrupt_allow_flag}, {32'd6, 1'b1})
    go(BTBCE_DI, 3'h0, 8'h00, 8'h00, 1'b1, 1'b0);
    `CK({cyc, global_interrupt_allow_flag}, {32'd6, 1'b0})
    @(posedge clk);
    clk_en <= 1'b0;
    op <= BTBCE_EI;
    start <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CK({busy, global_interrupt_allow_flag}, 2'b00)
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (5) @(posedge clk);
    #1 `CK({done, global_interrupt_allow_flag}, 2'b11)
  endtask
  initial begin
    {rst, clk_en, start, hs_ram, ext_area, ld} = 6'h30;
    op = BTBCE_NOP;
    bit_sel = 3'h0;
    {signed_jump_offset, acc_in, reg_b_in, reg_c_in, ld_val} = 40'h0;
    {rp_sel, bank_operand, read_waits, write_waits} = 12'h0;
    pc_in = 16'h1000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_bit();
    t_clear();
    t_loop();
    t_ctrl();
    results();
  end
endmodule // tb_top
